// *** rtl/asc_integrity.sv ***
`timescale 1ns/1ps
`default_nettype none
module asc_integrity #(
    parameter int MON_W = 64
) (
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    input  wire logic             i_enable,
    input  wire logic [MON_W-1:0] i_regs,
    output logic                  o_fault
);
    import asc_pkg::*;

    typedef struct packed {
        logic             armed;
        logic [MON_W-1:0] snap;
        logic             fault;
    } asc_int_state_t;

    asc_int_state_t s_q;
    asc_int_state_t s_d;

    // The reference is taken on the cycle the enable rises; a change is
    // latched until software drops the enable.
    always_comb begin
        s_d = s_q;
        if (!i_enable) begin
            s_d.armed = 1'b0;
            s_d.fault = 1'b0;
        end else if (!s_q.armed) begin
            s_d.armed = 1'b1;
            s_d.snap  = i_regs;
        end else if (i_regs != s_q.snap) begin
            s_d.fault = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_fault = s_q.fault;

endmodule
`default_nettype wire

// *** rtl/asc_sel_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module asc_sel_decode
    import asc_pkg::*;
(
    input  wire logic [asc_pkg::SEL_W-1:0] i_sel,
    output logic                           o_offset_sel,
    output logic                           o_gain_sel,
    output logic [2:0]                     o_cal_index
);
    import asc_pkg::*;

    logic in_bank;

    // Codes 110000..110111 pick an offset register, 111000..111111 a gain one.
    always_comb begin
        in_bank      = (i_sel[SEL_W-1:SEL_W-3] == SEL_BANK_MSBS) ||
                       (i_sel[SEL_W-1:SEL_BANK_LSB] == SEL_GAIN_BASE[SEL_W-1:SEL_BANK_LSB]);
        o_offset_sel = (i_sel[SEL_W-1:SEL_BANK_LSB] ==
                        SEL_OFFSET_BASE[SEL_W-1:SEL_BANK_LSB]);
        o_gain_sel   = (i_sel[SEL_W-1:SEL_BANK_LSB] ==
                        SEL_GAIN_BASE[SEL_W-1:SEL_BANK_LSB]);
        o_cal_index  = in_bank ? i_sel[SEL_BANK_LSB-1:0] : 3'h0;
    end

endmodule
`default_nettype wire

// *** rtl/asc_status_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module asc_status_regs #(
    parameter int MON_W = 64
) (
    input  wire logic                           i_clk,
    input  wire logic                           i_rstn,
    // Serial pins, sampled on i_clk.
    input  wire logic                           i_cs_n,
    input  wire logic                           i_sclk,
    input  wire logic                           i_din,
    output logic                                o_dout,
    output logic                                o_dout_oe,
    // Interface configuration bits.
    input  wire logic                           i_append_status,
    input  wire logic                           i_integrity_en,
    input  wire logic [MON_W-1:0]               i_monitored_regs,
    // Checksum verdict on the write just received.
    input  wire logic                           i_wr_check_fail,
    // Conversion side.
    input  wire logic                           i_result_stb,
    input  wire logic [asc_pkg::RESULT_W-1:0]   i_result,
    input  wire logic                           i_overrange,
    input  wire logic                           i_underrange,
    input  wire logic [asc_pkg::CHAN_W-1:0]     i_result_chan,
    input  wire logic                           i_cal_done,
    // Decoded access towards the other register holders.
    output logic [asc_pkg::SEL_W-1:0]           o_target_register_select,
    output logic                                o_offset_sel,
    output logic                                o_gain_sel,
    output logic [2:0]                          o_cal_index,
    output logic                                o_rd_stb,
    output logic                                o_wr_stb,
    output logic [7:0]                          o_wr_byte,
    output logic [7:0]                          o_status,
    output logic [asc_pkg::RESULT_W-1:0]        o_result
);
    import asc_pkg::*;

    typedef struct packed {
        asc_phase_t            phase;
        logic                  sclk_prev;
        logic [2:0]            bit_cnt;
        logic [6:0]            rx;
        logic [1:0]            wr_cnt;
        logic [TX_W-1:0]       tx;
        logic [5:0]            tx_left;
        logic [SEL_W-1:0]      sel;
        logic                  offset_sel;
        logic                  gain_sel;
        logic [2:0]            cal_index;
        logic                  rd_stb;
        logic                  wr_stb;
        logic [7:0]            wr_byte;
        logic                  pending;
        logic                  range_fault;
        logic                  wr_fault;
        logic [CHAN_W-1:0]     chan;
        logic [RESULT_W-1:0]   result;
        logic                  dout;
        logic                  dout_oe;
        logic [7:0]            status;
    } asc_state_t;

    asc_state_t s_q;
    asc_state_t s_d;

    logic             corrupt;
    logic             dec_offset;
    logic             dec_gain;
    logic [2:0]       dec_index;
    logic [7:0]       byte_in;
    logic [SEL_W-1:0] cmd_sel;
    logic             sclk_rise;
    logic             byte_done;
    logic             cmd_ok;
    logic             cmd_read;
    logic             status_rd;
    logic             data_rd;
    logic [7:0]       status_now;

    asc_integrity #(
        .MON_W (MON_W)
    ) u_integrity (
        .i_clk    (i_clk),
        .i_rstn   (i_rstn),
        .i_enable (i_integrity_en),
        .i_regs   (i_monitored_regs),
        .o_fault  (corrupt)
    );

    asc_sel_decode u_decode (
        .i_sel        (cmd_sel),
        .o_offset_sel (dec_offset),
        .o_gain_sel   (dec_gain),
        .o_cal_index  (dec_index)
    );

    // Byte assembly runs on SCLK rising edges seen in the system clock; SCLK
    // must therefore stay well below half of i_clk.
    always_comb begin
        sclk_rise  = i_sclk && !s_q.sclk_prev && !i_cs_n;
        byte_in    = {s_q.rx, i_din};
        cmd_sel    = byte_in[SEL_W-1:0];
        byte_done  = sclk_rise && (s_q.bit_cnt == BIT_LAST) && (s_q.phase != ASC_READ);
        cmd_ok     = byte_done && (s_q.phase == ASC_CMD) &&
                     !byte_in[CMD_ENABLE_BIT];
        cmd_read   = byte_in[CMD_READ_BIT];
        status_rd  = cmd_ok && cmd_read && (cmd_sel == SEL_STATUS);
        data_rd    = cmd_ok && cmd_read && (cmd_sel == SEL_DATA);
        status_now = {s_q.pending, s_q.range_fault, s_q.wr_fault, corrupt, s_q.chan};
    end

    always_comb begin
        s_d           = s_q;
        s_d.sclk_prev = i_sclk;
        s_d.rd_stb    = 1'b0;
        s_d.wr_stb    = 1'b0;

        // Serial framing.
        if (i_cs_n) begin
            s_d.phase   = ASC_CMD;
            s_d.bit_cnt = 3'h0;
            s_d.wr_cnt  = 2'h0;
            s_d.tx_left = 6'h00;
        end else if (sclk_rise) begin
            if (s_q.phase == ASC_READ) begin
                s_d.tx      = {s_q.tx[TX_W-2:0], 1'b0};
                s_d.tx_left = s_q.tx_left - 6'h01;
                if (s_q.tx_left == 6'h01) begin
                    s_d.phase   = ASC_CMD;
                    s_d.bit_cnt = 3'h0;
                end
            end else begin
                s_d.rx      = byte_in[6:0];
                s_d.bit_cnt = s_q.bit_cnt + 3'h1;
            end
        end

        // Command byte: a set enable bit leaves the link waiting for a command.
        if (cmd_ok) begin
            s_d.sel        = cmd_sel;
            s_d.offset_sel = dec_offset;
            s_d.gain_sel   = dec_gain;
            s_d.cal_index  = dec_index;
            s_d.wr_cnt     = 2'h0;
            if (cmd_read) begin
                s_d.phase  = ASC_READ;
                s_d.rd_stb = 1'b1;
                if (cmd_sel == SEL_STATUS) begin
                    s_d.tx      = {status_now, 24'h000000};
                    s_d.tx_left = LEN_STATUS;
                end else if (cmd_sel == SEL_DATA) begin
                    if (i_append_status) begin
                        s_d.tx      = {s_q.result, status_now};
                        s_d.tx_left = LEN_DATA_STAT;
                    end else begin
                        s_d.tx      = {s_q.result, 8'h00};
                        s_d.tx_left = LEN_DATA;
                    end
                end else begin
                    // Other registers live outside; they shift out as zeros here.
                    s_d.tx      = '0;
                    s_d.tx_left = LEN_OTHER;
                end
            end else begin
                s_d.phase = ASC_WRITE;
            end
        end else if (byte_done && (s_q.phase == ASC_WRITE)) begin
            s_d.wr_stb  = 1'b1;
            s_d.wr_byte = byte_in;
            s_d.wr_cnt  = s_q.wr_cnt + 2'h1;
            // The write ends after the longest register; the next byte is a command.
            if (s_q.wr_cnt == 2'(WR_BYTES_MAX - 1)) begin
                s_d.phase = ASC_CMD;
            end
        end

        // Pending flag: a data read raises it, a new result wins the same cycle.
        if (data_rd) begin
            s_d.pending = 1'b1;
        end
        if (i_result_stb || i_cal_done) begin
            s_d.pending = 1'b0;
        end

        // Result write with clamping and range flag.
        if (i_result_stb) begin
            s_d.range_fault = i_overrange || i_underrange;
            s_d.chan        = i_result_chan;
            if (i_overrange) begin
                s_d.result = RESULT_MAX;
            end else if (i_underrange) begin
                s_d.result = RESULT_MIN;
            end else begin
                s_d.result = i_result;
            end
        end

        // Write-check fault: a status read clears it, a new fault in the
        // same cycle is kept. Read checksums are never flagged here.
        if (status_rd) begin
            s_d.wr_fault = 1'b0;
        end
        if (i_wr_check_fail) begin
            s_d.wr_fault = 1'b1;
        end

        // Pin drive follows the next state so it leaves a flop.
        s_d.dout_oe = !i_cs_n;
        if (s_d.phase == ASC_READ) begin
            s_d.dout = s_d.tx[TX_W-1];
        end else begin
            s_d.dout = s_d.pending;
        end
        s_d.status = {s_d.pending, s_d.range_fault, s_d.wr_fault, corrupt, s_d.chan};
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_q           <= '0;
            s_q.phase     <= ASC_CMD;
            s_q.sclk_prev <= 1'b1;
            s_q.pending   <= STATUS_RESET[ST_PENDING_BIT];
            s_q.dout      <= STATUS_RESET[ST_PENDING_BIT];
            s_q.status    <= STATUS_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_dout                   = s_q.dout;
    assign o_dout_oe                = s_q.dout_oe;
    assign o_target_register_select = s_q.sel;
    assign o_offset_sel             = s_q.offset_sel;
    assign o_gain_sel               = s_q.gain_sel;
    assign o_cal_index              = s_q.cal_index;
    assign o_rd_stb                 = s_q.rd_stb;
    assign o_wr_stb                 = s_q.wr_stb;
    assign o_wr_byte                = s_q.wr_byte;
    assign o_status                 = s_q.status;
    assign o_result                 = s_q.result;

endmodule
`default_nettype wire

// *** shared/asc_pkg.sv ***
package asc_pkg;

    // Command byte layout.
    localparam int            CMD_ENABLE_BIT  = 7;
    localparam int            CMD_READ_BIT    = 6;
    localparam int            SEL_W           = 6;

    // Register selects handled here.
    localparam logic [5:0]    SEL_STATUS      = 6'h00;
    localparam logic [5:0]    SEL_DATA        = 6'h04;
    localparam logic [5:0]    SEL_OFFSET_BASE = 6'h30;
    localparam logic [5:0]    SEL_GAIN_BASE   = 6'h38;
    localparam logic [2:0]    SEL_BANK_MSBS   = 3'h6;
    localparam int            SEL_BANK_LSB    = 3;

    // Status register layout and reset value.
    localparam logic [7:0]    STATUS_RESET    = 8'h80;
    localparam int            ST_PENDING_BIT  = 7;
    localparam int            ST_RANGE_BIT    = 6;
    localparam int            ST_WRCHK_BIT    = 5;
    localparam int            ST_CORRUPT_BIT  = 4;
    localparam int            CHAN_W          = 4;

    // Result data.
    localparam int            RESULT_W        = 24;
    localparam logic [23:0]   RESULT_MAX      = 24'hffffff;
    localparam logic [23:0]   RESULT_MIN      = 24'h000000;

    // Serial shift lengths in bits.
    localparam int            TX_W            = 32;
    localparam logic [5:0]    LEN_STATUS      = 6'h08;
    localparam logic [5:0]    LEN_DATA        = 6'h18;
    localparam logic [5:0]    LEN_DATA_STAT   = 6'h20;
    localparam logic [5:0]    LEN_OTHER       = 6'h08;
    localparam logic [2:0]    BIT_LAST        = 3'h7;
    localparam int            WR_BYTES_MAX    = 3;

    typedef enum logic [1:0] {
        ASC_CMD,
        ASC_WRITE,
        ASC_READ
    } asc_phase_t;

endpackage

// *** sim/asc_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module asc_checker
    import asc_pkg::*;
#(
    parameter int MON_W = 64
) (
    input wire logic                         i_clk,
    input wire logic                         i_rstn,
    input wire logic                         i_cs_n,
    input wire logic                         o_dout_oe,
    input wire logic                         i_integrity_en,
    input wire logic [MON_W-1:0]             i_monitored_regs,
    input wire logic                         i_wr_check_fail,
    input wire logic                         i_result_stb,
    input wire logic                         i_overrange,
    input wire logic                         i_underrange,
    input wire logic [asc_pkg::CHAN_W-1:0]   i_result_chan,
    input wire logic                         i_cal_done,
    input wire logic [asc_pkg::SEL_W-1:0]    o_target_register_select,
    input wire logic                         o_rd_stb,
    input wire logic [7:0]                   o_status,
    input wire logic [asc_pkg::RESULT_W-1:0] o_result
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence seq_armed;
        i_integrity_en [*3];
    endsequence
    sequence seq_changed;
        i_integrity_en && (i_monitored_regs != $past(i_monitored_regs));
    endsequence
    pending_drop_a: assert property (i_result_stb |=> !o_status[ST_PENDING_BIT])
        else $error("pending flag high after a result write");
    cal_drop_a: assert property (i_cal_done |=> !o_status[ST_PENDING_BIT])
        else $error("pending flag high after a calibration write");
    range_flag_a: assert property (i_result_stb |=> o_status[ST_RANGE_BIT] == $past(i_overrange || i_underrange))
        else $error("range flag does not follow the written result");
    result_clamp_a: assert property (i_result_stb && (i_overrange || i_underrange) |=> o_result == ($past(i_overrange) ? RESULT_MAX : RESULT_MIN))
        else $error("out of range result not clamped");
    chan_tag_a: assert property (i_result_stb |=> o_status[3:0] == $past(i_result_chan))
        else $error("channel tag differs from result channel");
    chan_hold_a: assert property (!i_result_stb |=> $stable(o_status[3:0]))
        else $error("channel tag moved without a result");
    wrchk_set_a: assert property (i_wr_check_fail |=> o_status[ST_WRCHK_BIT])
        else $error("write check flag not set");
    wrchk_clear_a: assert property (o_rd_stb && o_target_register_select == SEL_STATUS && !i_wr_check_fail && !$past(i_wr_check_fail) |-> ##[0:1] !o_status[ST_WRCHK_BIT])
        else $error("status read left write check flag set");
    pending_set_a: assert property (o_rd_stb && o_target_register_select == SEL_DATA && !$past(i_result_stb || i_cal_done) |-> ##[0:1] o_status[ST_PENDING_BIT])
        else $error("data read left pending flag low");
    corrupt_set_a: assert property (seq_armed ##0 seq_changed |-> ##[1:3] o_status[ST_CORRUPT_BIT])
        else $error("monitored change not flagged");
    // The fault clears one cycle after the enable drops and the status image
    // one cycle later, so the flag is only seen clear on the third low sample.
    corrupt_clear_a: assert property (!i_integrity_en [*3] |-> !o_status[ST_CORRUPT_BIT])
        else $error("corruption flag set while checking is off");
    pin_enable_a: assert property (o_dout_oe == !$past(i_cs_n))
        else $error("data out enable does not follow chip select");
endmodule
bind asc_status_regs asc_checker #(.MON_W(MON_W)) chk_u (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_cs_n(i_cs_n), .o_dout_oe(o_dout_oe),
    .i_integrity_en(i_integrity_en),
    .i_monitored_regs(i_monitored_regs), .i_wr_check_fail(i_wr_check_fail),
    .i_result_stb(i_result_stb), .i_overrange(i_overrange), .i_underrange(i_underrange),
    .i_result_chan(i_result_chan), .i_cal_done(i_cal_done),
    .o_target_register_select(o_target_register_select), .o_rd_stb(o_rd_stb),
    .o_status(o_status), .o_result(o_result)
);
`default_nettype wire

// *** sim/asc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module asc_host_model (
    input  wire logic i_clk,
    input  wire logic i_dout,
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_din
);
    logic idle_bit;
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b1;
        o_din  = 1'b1;
    end
    // Two clocks low, two high; the device answers one clock after a rise, so
    // sampling one clock into the low half sees a settled bit.
    task automatic shift_bit(input logic b, output logic r);
        @(posedge i_clk);
        o_sclk <= 1'b0;
        o_din <= b;
        @(posedge i_clk);
        #1 r = i_dout;
        @(posedge i_clk);
        o_sclk <= 1'b1;
        @(posedge i_clk);
    endtask
    // Read data is taken as it comes; this host carries no read checksum check.
    task automatic frame(input logic [7:0] cmd, input int nbits, input logic [31:0] wdata,
                         output logic [31:0] rdata);
        logic r;
        rdata = '0;
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            shift_bit(cmd[i], r);
        end
        for (int i = nbits - 1; i >= 0; i--) begin
            shift_bit(wdata[i], r);
            rdata = {rdata[30:0], r};
        end
        shift_bit(1'b1, idle_bit);
        @(posedge i_clk);
        o_cs_n <= 1'b1;
        o_din <= ~o_din;
    endtask
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch at %0t got %h expected %h", $time, got, exp); end end
module testbench;
    import asc_pkg::*;
    logic        clk, rstn, cs_n, sclk, din, dout, dout_oe, append, integ_en, wr_fail;
    logic        res_stb, over, under, cal_done, rd_stb, wr_stb, offset_sel, gain_sel;
    logic [63:0] mon;
    logic [23:0] res, result;
    logic [3:0]  chan;
    logic [5:0]  sel;
    logic [2:0]  cal_index;
    logic [7:0]  wr_byte, status;
    logic [31:0] rdata;
    int          mismatches, samples_checked, cycles;
    asc_status_regs #(.MON_W(64)) dut_u (
        .i_clk(clk), .i_rstn(rstn), .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din), .o_dout(dout),
        .o_dout_oe(dout_oe), .i_append_status(append), .i_integrity_en(integ_en),
        .i_monitored_regs(mon), .i_wr_check_fail(wr_fail), .i_result_stb(res_stb),
        .i_result(res), .i_overrange(over), .i_underrange(under), .i_result_chan(chan),
        .i_cal_done(cal_done), .o_target_register_select(sel), .o_offset_sel(offset_sel),
        .o_gain_sel(gain_sel), .o_cal_index(cal_index), .o_rd_stb(rd_stb), .o_wr_stb(wr_stb),
        .o_wr_byte(wr_byte), .o_status(status), .o_result(result));
    asc_host_model host_u (.i_clk(clk), .i_dout(dout), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // The run should need about 1900 cycles; a hung handshake stops it here.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic put_result(input logic [23:0] v, input logic ov, input logic un,
                              input logic [3:0] ch);
        @(posedge clk);
        res_stb <= 1'b1;
        res <= v;
        over <= ov;
        under <= un;
        chan <= ch;
        @(posedge clk);
        res_stb <= 1'b0;
        settle(1);
    endtask
    initial begin
        {rstn, append, integ_en, wr_fail, res_stb, over, under, cal_done} = '0;
        mon = 64'h0123_4567_89ab_cdef;
        res = '0;
        chan = '0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        settle(2);
        `CHECK({status, dout_oe}, {STATUS_RESET, 1'b0})
        for (int s = 'h30; s <= 'h3f; s++) begin
            host_u.frame({2'b01, 6'(s)}, 8, '0, rdata);
            `CHECK({offset_sel, gain_sel, cal_index}, {s < 'h38, s >= 'h38, 3'(s)})
        end
        host_u.frame(8'h50, 8, '0, rdata);
        `CHECK({offset_sel, gain_sel, cal_index, rdata[7:0]}, 13'h0)
        host_u.frame(8'hfa, 0, '0, rdata);
        `CHECK(sel, 6'h10)
        $display("test decode done");
        for (int k = 0; k < 3; k++) begin
            put_result(24'h123456, k == 0, k == 1, 4'(k == 0 ? 15 : 5 * (k - 1)));
            `CHECK(result, k == 0 ? RESULT_MAX : k == 1 ? RESULT_MIN : 24'h123456)
            `CHECK(status, {1'b0, k < 2, 2'b00, 4'(k == 0 ? 15 : 5 * (k - 1))})
        end
        $display("test result done");
        for (int a = 0; a < 2; a++) begin
            append <= a[0];
            put_result(24'h123456, 1'b0, 1'b0, 4'(5 + a));
            host_u.frame(8'h44, 24 + 8 * a, '0, rdata);
            `CHECK(rdata, a ? {24'h123456, 8'h06} : {8'h00, 24'h123456})
            `CHECK({status[7], host_u.idle_bit}, 2'b11)
        end
        $display("test data read done");
        put_result(24'h000001, 1'b0, 1'b0, 4'h9);
        @(posedge clk);
        wr_fail <= 1'b1;
        @(posedge clk);
        wr_fail <= 1'b0;
        settle(1);
        `CHECK(status[5], 1'b1)
        host_u.frame(8'h40, 8, '0, rdata);
        `CHECK(rdata[7:0], 8'h29)
        `CHECK({status[5], host_u.idle_bit}, 2'b00)
        host_u.frame(8'h01, 16, 32'h0000_a55a, rdata);
        `CHECK(wr_byte, 8'h5a)
        host_u.frame(8'h44, 24, '0, rdata);
        @(posedge clk);
        cal_done <= 1'b1;
        @(posedge clk);
        cal_done <= 1'b0;
        settle(1);
        `CHECK(status[7], 1'b0)
        $display("test flags done");
        integ_en <= 1'b1;
        settle(4);
        `CHECK(status[4], 1'b0)
        mon <= mon ^ 64'h1;
        settle(4);
        `CHECK(status[4], 1'b1)
        integ_en <= 1'b0;
        settle(2);
        `CHECK(status[4], 1'b0)
        $display("test integrity done");
        end_of_test();
    end
endmodule
`default_nettype wire
